//--- src/vrc_pkg.sv
// Constants, types and helpers for the vectored request controller.
// Assumes a single 50 MHz clock, synchronous reset, AXI4-Lite slave access.
package vrc_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int VRC_N = 32;
	localparam int VRC_PW = 4;
	localparam int VRC_WIN_BITS = 14;
	localparam logic [31:0] VRC_BASE = 32'hFFFF_C000;

	// ****************************************************************
	// Register offsets inside the window
	// ****************************************************************
	localparam logic [13:0] OFF_VEC_STAT = 14'h0000;
	localparam logic [13:0] OFF_FAST_STAT = 14'h0004;
	localparam logic [13:0] OFF_RAW = 14'h0008;
	localparam logic [13:0] OFF_CLASS = 14'h000C;
	localparam logic [13:0] OFF_ENABLE = 14'h0010;
	localparam logic [13:0] OFF_VEC_ADDR = 14'h0014;
	localparam logic [13:0] OFF_DEF_VEC = 14'h0018;
	localparam logic [13:0] OFF_EVT_STAT = 14'h001C;
	localparam logic [13:0] OFF_EVT_MASK = 14'h0020;
	localparam logic [13:0] OFF_VEC_TAB = 14'h0100;
	localparam logic [13:0] OFF_PRIO_TAB = 14'h0200;

	// ****************************************************************
	// Reset values and event bits
	// ****************************************************************
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [3:0] RST_PRIO = 4'hF;
	localparam int EVT_W = 3;
	localparam int EVT_FAST_RISE = 0;
	localparam int EVT_NORM_RISE = 1;
	localparam int EVT_BUS_ERR = 2;
	localparam logic [2:0] RST_EVT = 3'h0;

	// ****************************************************************
	// Bus answers
	// ****************************************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Outcome of the vectored priority search
	typedef struct packed {
		logic valid;
		logic [4:0] idx;
		logic [VRC_PW-1:0] prio;
	} vrc_pick_t;

	// Merge a write into a word under byte strobes
	function automatic logic [31:0] vrc_strobe(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_w[8*b +: 8];
			end
		end
		return res;
	endfunction : vrc_strobe

endpackage : vrc_pkg

//--- src/vrc_arbiter.sv
// Priority search over the pending vectored requests.
// Assumes a lower priority value means more urgent; purely combinational.
`timescale 1ns/100ps
module vrc_arbiter import vrc_pkg::*; (
	input wire logic [VRC_N-1:0] pend, // Pending vectored requests
	input wire logic [VRC_PW-1:0] prio [VRC_N], // Priority per input
	output vrc_pick_t winner // Best pending request
);

	// ****************************************************************
	// Search
	// ****************************************************************
	// Walk from the top down so an equal value lets the lower index win
	always_comb begin
		winner = '0;
		for (int i = VRC_N - 1; i >= 0; i--) begin
			if (pend[i] && (!winner.valid || prio[i] <= winner.prio)) begin
				winner.valid = 1'b1;
				winner.idx = 5'(i);
				winner.prio = prio[i];
			end
		end
	end

endmodule : vrc_arbiter

//--- src/vrc_controller.sv
// Vectored request controller with AXI4-Lite register access.
// Assumes request inputs come from logic on CLK and stay high until served.
`timescale 1ns/100ps
module vrc_controller import vrc_pkg::*; (
	input wire logic CLK, // System clock, 50 MHz
	input wire logic RESET, // Synchronous reset, active high
	input wire logic [VRC_N-1:0] IRQ_IN, // Peripheral request lines
	output logic FAST_REQUEST_OUTPUT, // Fast request to the core
	output logic NORMAL_REQUEST_OUTPUT, // Normal request to the core
	output logic EVT_IRQ, // Event interrupt, level
	input wire logic [31:0] S_AXI_AWADDR, // Write address
	input wire logic S_AXI_AWVALID, // Write address valid
	output logic S_AXI_AWREADY, // Write address ready
	input wire logic [31:0] S_AXI_WDATA, // Write data
	input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes
	input wire logic S_AXI_WVALID, // Write data valid
	output logic S_AXI_WREADY, // Write data ready
	output logic [1:0] S_AXI_BRESP, // Write response
	output logic S_AXI_BVALID, // Write response valid
	input wire logic S_AXI_BREADY, // Write response ready
	input wire logic [31:0] S_AXI_ARADDR, // Read address
	input wire logic S_AXI_ARVALID, // Read address valid
	output logic S_AXI_ARREADY, // Read address ready
	output logic [31:0] S_AXI_RDATA, // Read data
	output logic [1:0] S_AXI_RRESP, // Read response
	output logic S_AXI_RVALID, // Read data valid
	input wire logic S_AXI_RREADY // Read data ready
);

	// ****************************************************************
	// Configuration state
	// ****************************************************************
	logic [31:0] class_reg;
	logic [31:0] enable_reg;
	logic [31:0] def_vec_reg;
	logic [EVT_W-1:0] evt_stat_reg;
	logic [EVT_W-1:0] evt_mask_reg;
	logic [31:0] vec_tab_reg [VRC_N];
	logic [VRC_PW-1:0] prio_tab_reg [VRC_N];
	logic fast_q_reg;
	logic norm_q_reg;

	// ****************************************************************
	// Request classification
	// ****************************************************************
	logic [31:0] active;
	logic [31:0] fast_act;
	logic [31:0] norm_act;
	logic [31:0] vec_addr;
	vrc_pick_t pick;

	assign active = IRQ_IN & enable_reg;
	assign fast_act = active & class_reg;
	assign norm_act = active & ~class_reg;
	// Fast class is removed from the vectored search, so it always outranks it
	assign FAST_REQUEST_OUTPUT = |fast_act;
	assign NORMAL_REQUEST_OUTPUT = |norm_act;

	vrc_arbiter vrc_arbiter_inst (
		.pend(norm_act),
		.prio(prio_tab_reg),
		.winner(pick)
	);

	// Empty search answers with the default handler address
	assign vec_addr = pick.valid ? vec_tab_reg[pick.idx] : def_vec_reg;

	// ****************************************************************
	// Write channel
	// ****************************************************************
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [31:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic aw_fire;
	logic w_fire;
	logic do_write;

	assign S_AXI_AWREADY = !aw_hold_reg && !bvalid_reg;
	assign S_AXI_WREADY = !w_hold_reg && !bvalid_reg;
	assign aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
	assign w_fire = S_AXI_WVALID && S_AXI_WREADY;
	assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP = bresp_reg;

	always_ff @(posedge CLK) begin
		if (RESET || do_write) begin
			aw_hold_reg <= 1'b0;
		end else if (aw_fire) begin
			aw_hold_reg <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET || do_write) begin
			w_hold_reg <= 1'b0;
		end else if (w_fire) begin
			w_hold_reg <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (aw_fire) begin
			aw_addr_reg <= S_AXI_AWADDR;
		end
		if (w_fire) begin
			w_data_reg <= S_AXI_WDATA;
			w_strb_reg <= S_AXI_WSTRB;
		end
	end

	// ****************************************************************
	// Write decode
	// ****************************************************************
	// Window check keeps the block to its own 16 kB slot on the main bus
	logic [13:0] wr_off;
	logic wr_in_win;
	logic wr_class;
	logic wr_enable;
	logic wr_def_vec;
	logic wr_evt_stat;
	logic wr_evt_mask;
	logic wr_vec_tab;
	logic wr_prio_tab;
	logic wr_ro;
	logic wr_ok;
	logic [4:0] wr_idx;
	logic [31:0] wr_word;

	assign wr_off = aw_addr_reg[VRC_WIN_BITS-1:0];
	assign wr_in_win = aw_addr_reg[31:VRC_WIN_BITS] ==
		VRC_BASE[31:VRC_WIN_BITS];
	assign wr_idx = wr_off[6:2];
	assign wr_class = wr_in_win && wr_off == OFF_CLASS;
	assign wr_enable = wr_in_win && wr_off == OFF_ENABLE;
	assign wr_def_vec = wr_in_win && wr_off == OFF_DEF_VEC;
	assign wr_evt_stat = wr_in_win && wr_off == OFF_EVT_STAT;
	assign wr_evt_mask = wr_in_win && wr_off == OFF_EVT_MASK;
	assign wr_vec_tab = wr_in_win && wr_off[13:7] == OFF_VEC_TAB[13:7];
	assign wr_prio_tab = wr_in_win && wr_off[13:7] == OFF_PRIO_TAB[13:7];
	// Status words other than the event status take writes with no effect
	assign wr_ro = wr_in_win && (wr_off == OFF_VEC_STAT ||
		wr_off == OFF_FAST_STAT || wr_off == OFF_RAW ||
		wr_off == OFF_VEC_ADDR);
	assign wr_ok = wr_class || wr_enable || wr_def_vec || wr_evt_stat ||
		wr_evt_mask || wr_vec_tab || wr_prio_tab || wr_ro;
	assign wr_word = vrc_strobe(RST_WORD, w_data_reg, w_strb_reg);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	// Class and priority may change at any time; they act on the next cycle
	always_ff @(posedge CLK) begin
		if (RESET) begin
			class_reg <= RST_WORD;
			enable_reg <= RST_WORD;
			def_vec_reg <= RST_WORD;
			evt_mask_reg <= RST_EVT;
		end else if (do_write) begin
			if (wr_class) begin
				class_reg <= vrc_strobe(class_reg, w_data_reg,
					w_strb_reg);
			end
			if (wr_enable) begin
				enable_reg <= vrc_strobe(enable_reg, w_data_reg, w_strb_reg);
			end
			if (wr_def_vec) begin
				def_vec_reg <= vrc_strobe(def_vec_reg, w_data_reg,
					w_strb_reg);
			end
			if (wr_evt_mask) begin
				evt_mask_reg <= wr_word[EVT_W-1:0];
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			for (int i = 0; i < VRC_N; i++) begin
				vec_tab_reg[i] <= RST_WORD;
				prio_tab_reg[i] <= RST_PRIO;
			end
		end else if (do_write) begin
			if (wr_vec_tab) begin
				vec_tab_reg[wr_idx] <= vrc_strobe(vec_tab_reg[wr_idx],
					w_data_reg, w_strb_reg);
			end
			if (wr_prio_tab && w_strb_reg[0]) begin
				prio_tab_reg[wr_idx] <= w_data_reg[VRC_PW-1:0];
			end
		end
	end

	// ****************************************************************
	// Events
	// ****************************************************************
	logic [EVT_W-1:0] evt_set;
	logic [EVT_W-1:0] evt_clr;
	logic rd_err;

	assign evt_set[EVT_FAST_RISE] = FAST_REQUEST_OUTPUT && !fast_q_reg;
	assign evt_set[EVT_NORM_RISE] = NORMAL_REQUEST_OUTPUT && !norm_q_reg;
	assign evt_set[EVT_BUS_ERR] = (do_write && !wr_ok) || rd_err;
	assign evt_clr = (do_write && wr_evt_stat) ? wr_word[EVT_W-1:0] : '0;
	assign EVT_IRQ = |(evt_stat_reg & evt_mask_reg);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			fast_q_reg <= 1'b0;
			norm_q_reg <= 1'b0;
			evt_stat_reg <= RST_EVT;
		end else begin
			fast_q_reg <= FAST_REQUEST_OUTPUT;
			norm_q_reg <= NORMAL_REQUEST_OUTPUT;
			// A new event wins over a clear in the same cycle
			evt_stat_reg <= (evt_stat_reg & ~evt_clr) | evt_set;
		end
	end

	// ****************************************************************
	// Read channel
	// ****************************************************************
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic ar_fire;
	logic [13:0] rd_off;
	logic [4:0] rd_idx;
	logic rd_in_win;
	logic rd_hit;
	logic [31:0] rd_word;

	assign S_AXI_ARREADY = !rvalid_reg;
	assign ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;
	assign rd_off = S_AXI_ARADDR[VRC_WIN_BITS-1:0];
	assign rd_idx = rd_off[6:2];
	assign rd_in_win = S_AXI_ARADDR[31:VRC_WIN_BITS] ==
		VRC_BASE[31:VRC_WIN_BITS];
	assign rd_err = ar_fire && !rd_hit;
	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RDATA = rdata_reg;
	assign S_AXI_RRESP = rresp_reg;

	always_comb begin
		rd_hit = rd_in_win;
		rd_word = RST_WORD;
		if (rd_off == OFF_VEC_STAT) begin
			rd_word = norm_act;
		end else if (rd_off == OFF_FAST_STAT) begin
			rd_word = fast_act;
		end else if (rd_off == OFF_RAW) begin
			rd_word = IRQ_IN;
		end else if (rd_off == OFF_CLASS) begin
			rd_word = class_reg;
		end else if (rd_off == OFF_ENABLE) begin
			rd_word = enable_reg;
		end else if (rd_off == OFF_VEC_ADDR) begin
			rd_word = vec_addr;
		end else if (rd_off == OFF_DEF_VEC) begin
			rd_word = def_vec_reg;
		end else if (rd_off == OFF_EVT_STAT) begin
			rd_word[EVT_W-1:0] = evt_stat_reg;
		end else if (rd_off == OFF_EVT_MASK) begin
			rd_word[EVT_W-1:0] = evt_mask_reg;
		end else if (rd_off[13:7] == OFF_VEC_TAB[13:7]) begin
			rd_word = vec_tab_reg[rd_idx];
		end else if (rd_off[13:7] == OFF_PRIO_TAB[13:7]) begin
			rd_word[VRC_PW-1:0] = prio_tab_reg[rd_idx];
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= RST_WORD;
			rresp_reg <= RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_hit ? rd_word : RST_WORD;
			rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			rvalid_reg <= 1'b0;
		end
	end

endmodule : vrc_controller

//--- dv/vrc_monitor.sv
// Port checker for the vectored request controller.
// Assumes a bind onto vrc_controller; one clock, synchronous reset.
`timescale 1ns/100ps
module vrc_monitor import vrc_pkg::*; (
	input wire logic CLK, // Clock
	input wire logic RESET, // Reset
	input wire logic [VRC_N-1:0] IRQ_IN, // Requests
	input wire logic FAST_REQUEST_OUTPUT, // Fast out
	input wire logic NORMAL_REQUEST_OUTPUT, // Normal out
	input wire logic S_AXI_AWREADY, // Write addr ready
	input wire logic S_AXI_WREADY, // Write data ready
	input wire logic [1:0] S_AXI_BRESP, // Write resp
	input wire logic S_AXI_BVALID, // Write resp valid
	input wire logic S_AXI_BREADY, // Write resp ready
	input wire logic [31:0] S_AXI_ARADDR, // Read addr
	input wire logic S_AXI_ARVALID, // Read addr valid
	input wire logic S_AXI_ARREADY, // Read addr ready
	input wire logic [31:0] S_AXI_RDATA, // Read data
	input wire logic [1:0] S_AXI_RRESP, // Read resp
	input wire logic S_AXI_RVALID, // Read valid
	input wire logic S_AXI_RREADY // Read ready
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	a_fast_quiet: assert property (
		IRQ_IN == '0 |-> !FAST_REQUEST_OUTPUT) else $error("Stray fast");
	a_norm_quiet: assert property (
		IRQ_IN == '0 |-> !NORMAL_REQUEST_OUTPUT) else $error("Stray normal");
	a_reset_low: assert property (
		$fell(RESET) |-> !FAST_REQUEST_OUTPUT && !NORMAL_REQUEST_OUTPUT)
		else $error("Output high after reset");
	a_one_class: assert property (
		$onehot(IRQ_IN) |-> !(FAST_REQUEST_OUTPUT && NORMAL_REQUEST_OUTPUT))
		else $error("One input in two classes");
	a_out_window: assert property (
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[31:14] != VRC_BASE[31:14]
		|=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0000_0000)
		else $error("Outside read not refused");
	a_in_window: assert property (
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == VRC_BASE + 32'(OFF_CLASS)
		|=> S_AXI_RVALID && S_AXI_RRESP == RESP_OKAY) else $error("Class read bad");
	a_rd_hold: assert property (
		S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("Read answer dropped");
	a_wr_hold: assert property (
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("Write answer dropped");
	a_busy_block: assert property (
		S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("Write taken while answering");
	a_rd_block: assert property (
		S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("Read taken while busy");
endmodule : vrc_monitor

bind vrc_controller vrc_monitor vrc_monitor_inst (.CLK, .RESET, .IRQ_IN,
	.FAST_REQUEST_OUTPUT, .NORMAL_REQUEST_OUTPUT, .S_AXI_AWREADY,
	.S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
	.S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
	.S_AXI_RVALID, .S_AXI_RREADY);

//--- dv/vrc_bus_agent.sv
// Model of the processor side: a register bus master issuing single words.
// Assumes the caller enters its tasks from one process at a time.
`timescale 1ns/100ps
module vrc_bus_agent (
	input wire logic clk, // Clock
	output logic [31:0] awaddr, // Write addr
	output logic awvalid, // Write addr valid
	input wire logic awready, // Write addr ready
	output logic [31:0] wdata, // Write data
	output logic [3:0] wstrb, // Byte strobes
	output logic wvalid, // Write data valid
	input wire logic wready, // Write data ready
	input wire logic [1:0] bresp, // Write resp
	input wire logic bvalid, // Write resp valid
	output logic bready, // Write resp ready
	output logic [31:0] araddr, // Read addr
	output logic arvalid, // Read addr valid
	input wire logic arready, // Read addr ready
	input wire logic [31:0] rdata, // Read data
	input wire logic [1:0] rresp, // Read resp
	input wire logic rvalid, // Read valid
	output logic rready, // Read ready
	output logic hang // A wait ran out
);
	// ****************************************************************
	// Transfers, answer taken promptly or late at random
	// ****************************************************************
	initial {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
	initial {araddr, arvalid, rready, hang} = '0;
	task automatic wr(input logic [31:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge clk);
		{awaddr, wdata, wstrb, awvalid, wvalid} <= {a, d, 4'hF, 2'b11};
		bready <= 1'($urandom_range(0, 1));
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~awaddr};
			if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~wdata};
			if (bready && bvalid) break;
			if (bvalid) bready <= 1'b1;
		end
		r = bresp;
		bready <= 1'b0;
		if (n == 64) hang <= 1'b1;
	endtask : wr
	task automatic rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge clk);
		{araddr, arvalid} <= {a, 1'b1};
		rready <= 1'($urandom_range(0, 1));
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~araddr};
			if (rready && rvalid) break;
			if (rvalid) rready <= 1'b1;
		end
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
		if (n == 64) hang <= 1'b1;
	endtask : rd
endmodule : vrc_bus_agent

//--- dv/tb_vrc_controller.sv
// Self-checking bench for the vectored request controller.
// Assumes the bus agent model beside the design and the bound checker.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
	n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_vrc_controller import vrc_pkg::*;;
	logic CLK = 1'b0;
	logic RESET = 1'b1;
	logic [VRC_N-1:0] IRQ_IN = '0;
	logic FAST_REQUEST_OUTPUT, NORMAL_REQUEST_OUTPUT, EVT_IRQ, hang;
	logic [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
	logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
	logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
	logic S_AXI_RVALID, S_AXI_RREADY;
	logic [31:0] vt [VRC_N];
	logic [3:0] pr [VRC_N];
	logic [31:0] defv, cls, irq, d;
	int n_mismatch = 0, checked = 0, k, n;
	always #10 CLK = ~CLK;
	vrc_controller vrc_controller_inst (.CLK, .RESET, .IRQ_IN,
		.FAST_REQUEST_OUTPUT, .NORMAL_REQUEST_OUTPUT, .EVT_IRQ, .S_AXI_AWADDR,
		.S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
		.S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
		.S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
		.S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
	vrc_bus_agent vrc_bus_agent_inst (.clk(CLK), .awaddr(S_AXI_AWADDR),
		.awvalid(S_AXI_AWVALID), .awready(S_AXI_AWREADY), .wdata(S_AXI_WDATA),
		.wstrb(S_AXI_WSTRB), .wvalid(S_AXI_WVALID), .wready(S_AXI_WREADY),
		.bresp(S_AXI_BRESP), .bvalid(S_AXI_BVALID), .bready(S_AXI_BREADY),
		.araddr(S_AXI_ARADDR), .arvalid(S_AXI_ARVALID),
		.arready(S_AXI_ARREADY), .rdata(S_AXI_RDATA), .rresp(S_AXI_RRESP),
		.rvalid(S_AXI_RVALID), .rready(S_AXI_RREADY), .hang(hang));
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] ad(input logic [13:0] o);
		return VRC_BASE + 32'(o);
	endfunction : ad
	// Most urgent pending input, lowest index on a tie
	function automatic logic [31:0] best(input logic [31:0] p);
		int b;
		b = -1;
		for (int i = 0; i < VRC_N; i++)
			if (p[i] && (b < 0 || pr[i] < pr[b])) b = i;
		return (b < 0) ? defv : vt[b];
	endfunction : best
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		vrc_bus_agent_inst.wr(a, v, r);
	endtask : wr
	task automatic rchk(input string nm, input logic [13:0] o,
		input logic [31:0] e);
		vrc_bus_agent_inst.rd(ad(o), d, r);
		`CHK(nm, e, d)
	endtask : rchk
	task automatic evt_is(input logic e);
		for (n = 0; n < 8 && EVT_IRQ !== e; n++) @(negedge CLK);
		`CHK("evt irq", e, EVT_IRQ)
		if (n == 8) end_of_test();
	endtask : evt_is
	task automatic end_of_test;
		if (n_mismatch == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	always @(posedge hang) begin
		n_mismatch++;
		end_of_test();
	end
	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		void'($urandom(32'h0000_d6ef));
		repeat (20) @(posedge CLK);
		RESET <= 1'b0;
		IRQ_IN <= 32'hFFFF_FFFF;
		@(negedge CLK);
		`CHK("fast rst", 1'b0, FAST_REQUEST_OUTPUT)
		`CHK("norm rst", 1'b0, NORMAL_REQUEST_OUTPUT)
		rchk("class", OFF_CLASS, RST_WORD);
		rchk("prio", OFF_PRIO_TAB + 14'h0014, 32'(RST_PRIO));
		defv = $urandom;
		wr(ad(OFF_DEF_VEC), defv);
		for (n = 0; n < VRC_N; n++) begin
			vt[n] = $urandom;
			pr[n] = 4'($urandom_range(0, 5));
			wr(ad(OFF_VEC_TAB) + 32'(4 * n), vt[n]);
			wr(ad(OFF_PRIO_TAB) + 32'(4 * n), 32'(pr[n]));
		end
		wr(ad(OFF_ENABLE), 32'hFFFF_FFFF);
		for (k = 0; k < 48; k++) begin
			cls = (k == 0) ? '1 : (k == 1) ? '0 : $urandom;
			n = $urandom_range(0, VRC_N - 1);
			pr[n] = 4'($urandom_range(0, 15));
			wr(ad(OFF_PRIO_TAB) + 32'(4 * n), 32'(pr[n]));
			wr(ad(OFF_CLASS), cls);
			`CHK("wr resp", RESP_OKAY, r)
			irq = (k % 4 == 2) ? 32'h0000_0001 << n : $urandom & $urandom;
			@(posedge CLK);
			IRQ_IN <= irq;
			@(negedge CLK);
			`CHK("fast", |(irq & cls), FAST_REQUEST_OUTPUT)
			`CHK("norm", |(irq & ~cls), NORMAL_REQUEST_OUTPUT)
			rchk("fast stat", OFF_FAST_STAT, irq & cls);
			rchk("norm stat", OFF_VEC_STAT, irq & ~cls);
			rchk("vec", OFF_VEC_ADDR, best(irq & ~cls));
			rchk("raw", OFF_RAW, irq);
		end
		IRQ_IN <= '0;
		wr(ad(OFF_EVT_STAT), 32'h0000_0007);
		wr(ad(OFF_EVT_MASK), 32'h0000_0000);
		vrc_bus_agent_inst.rd(32'hFFFF_8000, d, r);
		`CHK("rd err", RESP_SLVERR, r)
		wr(ad(14'h0024), 32'h0000_0000);
		`CHK("wr err", RESP_SLVERR, r)
		repeat (3) @(negedge CLK);
		evt_is(1'b0);
		rchk("evt stat", OFF_EVT_STAT, 32'h0000_0004);
		wr(ad(OFF_EVT_MASK), 32'h0000_0004);
		evt_is(1'b1);
		wr(ad(OFF_EVT_STAT), 32'h0000_0004);
		evt_is(1'b0);
		wr(ad(OFF_EVT_MASK), 32'h0000_0001);
		wr(ad(OFF_CLASS), 32'hFFFF_FFFF);
		@(posedge CLK);
		IRQ_IN <= 32'h0000_0008;
		evt_is(1'b1);
		// Read-only word takes a write without complaint
		wr(ad(OFF_VEC_ADDR), 32'hFFFF_FFFF);
		`CHK("ro wr resp", RESP_OKAY, r)
		// Disabling every input silences both outputs
		wr(ad(OFF_ENABLE), 32'h0000_0000);
		@(negedge CLK);
		`CHK("fast off", 1'b0, FAST_REQUEST_OUTPUT)
		`CHK("norm off", 1'b0, NORMAL_REQUEST_OUTPUT)
		rchk("enable", OFF_ENABLE, 32'h0000_0000);
		rchk("fast off stat", OFF_FAST_STAT, 32'h0000_0000);
		end_of_test();
	end
endmodule : tb_vrc_controller
